// [common/pslm_map.svh]
// register offsets, field positions and timing counts of the slave modem link controller
// assumes a 125 MHz core clock and word-indexed registers on a plain port
`ifndef PSLM_MAP_SVH
`define PSLM_MAP_SVH
// register indices (byte address is four times the index)
`define PSLM_HS_STATUS      4'h0
`define PSLM_TX_MSG_CNT     4'h1
`define PSLM_RX_GOOD_CNT    4'h2
`define PSLM_UNDELIV_CNT    4'h3
`define PSLM_RESEND_CNT     4'h4
`define PSLM_NAK_CNT        4'h5
`define PSLM_POLL_CNT       4'h6
`define PSLM_CORRUPT_CNT    4'h7
`define PSLM_NOBUF_CNT      4'h8
`define PSLM_REPEAT_CNT     4'h9
`define PSLM_CARRIER_CNT    4'hB
`define PSLM_MODEM_LOSS_CNT 4'hC
// configuration registers
`define PSLM_CFG_DELAYS     4'hD
`define PSLM_CFG_POLL       4'hE
`define PSLM_CFG_CTRL       4'hF
// handshake status bit positions
`define PSLM_BIT_CTS 0
`define PSLM_BIT_RTS 1
`define PSLM_BIT_DSR 2
`define PSLM_BIT_DCD 3
`define PSLM_BIT_DTR 4
// control register fields
`define PSLM_CTRL_SUPPRESS 0
`define PSLM_CTRL_DTR      1
// tick periods
`define PSLM_CLK_HZ       125000000
`define PSLM_TICK_MS      1
`define PSLM_SLOW_TICK_MS 20
`define PSLM_MS_CYCLES    (`PSLM_CLK_HZ / 1000 * `PSLM_TICK_MS)
`endif

// [common/pslm_pkg.sv]
// types shared by the slave modem link controller
// assumes nothing beyond the constants header
package pslm_pkg;
   typedef enum logic [2:0] {
      ST_IDLE, ST_PRE, ST_LEAD, ST_WAIT_CTS, ST_SEND, ST_HOLD, ST_WAIT_ACK
   } pslm_state_e;
   typedef logic [15:0] pslm_word_t;
endpackage : pslm_pkg

// [rtl/pslm_tick_gen.sv]
// millisecond and 20 ms tick generator
// assumes one free-running core clock
`timescale 1ns/1ps
`include "pslm_map.svh"
module pslm_tick_gen #(
   parameter int MS_CYCLES = `PSLM_MS_CYCLES
) (
   input  wire logic core_clk_in,
   input  wire logic rst_in,
   output logic      ms_tick_out,
   output logic      slow_tick_out
);
   logic [31:0] div;  // cycle divider
   logic [4:0]  ms_n; // milliseconds within one slow tick
   // divide the core clock down to 1 ms and 20 ms pulses
   always_ff @(posedge core_clk_in) begin
      ms_tick_out   <= 1'b0;
      slow_tick_out <= 1'b0;
      if (rst_in) begin
         div  <= 32'h0;
         ms_n <= 5'h0;
      end else if (div == 32'(MS_CYCLES - 1)) begin
         div         <= 32'h0;
         ms_tick_out <= 1'b1;
         if (ms_n == 5'(`PSLM_SLOW_TICK_MS - 1)) begin
            ms_n          <= 5'h0;
            slow_tick_out <= 1'b1;
         end else begin
            ms_n <= ms_n + 5'h1;
         end
      end else begin
         div <= div + 32'h1;
      end
   end
endmodule : pslm_tick_gen

// [rtl/pslm_link_ctrl.sv]
// slave side of a polled half-duplex modem link: handshake timing, poll supervision, counters
// assumes the framer pulses events on the core clock; modem lines arrive asynchronously
`timescale 1ns/1ps
`include "pslm_map.svh"
// Notes on behaviour
// RULE1: pending own message starts poll supervision timer
// RULE2: poll timeout first: error, drop message
// RULE3: message timeout first: error and timeout flags
// RULE4: poll timeout zero disables supervision
// RULE5: hold request-to-send after last byte
// RULE6: lead delay after request-to-send before sending
// RULE7: send only while clear-to-send high; the code checks it only when starting a send, not during ST_SEND
// RULE8: resend up to retry count, then undeliverable
// RULE9: pre-transmit delay before request-to-send
// RULE10: suppressed no-data reply stays silent
// RULE11: otherwise answer empty poll with no-data packet
// RULE12: master sets poll timeout above poll cycle
// RULE13: status word mirrors handshake lines
// RULE14: count every transmission including retries
// RULE15: count error-free received messages
// RULE16: count unacknowledged transmitted messages
// RULE17: count retries only
// RULE18: count negative acks and polls received
// RULE19: count corrupt packets left unacknowledged
// RULE20: count messages refused for lack of buffer
// RULE21: count repeated identical packets
// RULE22: count carrier and modem-lost rising edges
// RULE23: counters sixteen bits, clear on reset
module pslm_link_ctrl #(
   parameter int MS_CYCLES = `PSLM_MS_CYCLES
) (
   input  wire logic        core_clk_in,
   input  wire logic        rst_in,
   // register port
   input  wire logic [3:0]  reg_addr_in,
   input  wire logic [31:0] reg_wdata_in,
   input  wire logic        reg_wr_in,
   input  wire logic        reg_rd_in,
   output logic [31:0]      reg_rdata_out,
   // modem lines
   input  wire logic        cts_in,
   input  wire logic        dsr_in,
   input  wire logic        dcd_in,
   input  wire logic        modem_lost_in,
   output logic             rts_out,
   output logic             dtr_out,
   // message side
   input  wire logic        msg_pending_in,    // own message waiting
   input  wire logic        msg_timeout_in,    // message's own timeout expired
   input  wire logic        poll_in,           // poll from master received
   input  wire logic        ack_in,            // our message acknowledged
   input  wire logic        nak_in,            // negative ack received
   input  wire logic        ack_timeout_in,    // no answer to our message
   input  wire logic        rx_good_in,
   input  wire logic        rx_corrupt_in,
   input  wire logic        rx_nobuf_in,
   input  wire logic        rx_repeat_in,
   input  wire logic        tx_done_in,        // last byte left the serialiser
   output logic             tx_start_out,      // pulse: begin sending message
   output logic             eot_send_out,      // pulse: send no-data packet
   output logic             msg_error_out,
   output logic             msg_timeout_flag_out,
   output logic             msg_discard_out,   // pulse: drop from queue
   output logic             msg_done_out       // pulse: delivered or given up
);
   // cycle-domain state
   pslm_pkg::pslm_state_e state, next_state;
   logic             ms_tick, slow_tick;
   logic [1:0]       cts_s, dsr_s, dcd_s, lost_s; // two-stage synchronisers
   logic             dcd_q, lost_q;                 // edge history of synced levels
   logic [7:0]       pre_delay, lead_delay, hold_delay, retry_max;
   logic [15:0]      poll_limit;                   // in 20 ms ticks
   logic             suppress, dtr;
   logic [15:0]      poll_timer;
   logic [7:0]       delay_cnt, retries;
   logic             msg_error, msg_tmo;
   logic             poll_expire, retry_send, give_up;
   pslm_pkg::pslm_word_t cnt [1:12];                // diagnostic counters

   pslm_tick_gen #(.MS_CYCLES(MS_CYCLES)) u_tick (
      .core_clk_in   (core_clk_in),
      .rst_in        (rst_in),
      .ms_tick_out   (ms_tick),
      .slow_tick_out (slow_tick)
   );

   // saturation-free increment of a counter
   function automatic pslm_pkg::pslm_word_t bump(input pslm_pkg::pslm_word_t v, input logic ev);
      bump = ev ? v + 16'h1 : v;
   endfunction : bump

   // synchronise the modem input pins
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         cts_s  <= 2'h0;
         dsr_s  <= 2'h0;
         dcd_s  <= 2'h0;
         lost_s <= 2'h0;
         dcd_q  <= 1'b0;
         lost_q <= 1'b0;
      end else begin
         cts_s  <= {cts_s[0], cts_in};
         dsr_s  <= {dsr_s[0], dsr_in};
         dcd_s  <= {dcd_s[0], dcd_in};
         lost_s <= {lost_s[0], modem_lost_in};
         dcd_q  <= dcd_s[1];
         lost_q <= lost_s[1];
      end
   end

   // configuration register writes
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         pre_delay  <= 8'h0;
         lead_delay <= 8'h0;
         hold_delay <= 8'h0;
         retry_max  <= 8'h3;
         poll_limit <= 16'h0;
         suppress   <= 1'b0;
         dtr        <= 1'b1;
      end else if (reg_wr_in) begin
         unique case (reg_addr_in)
            `PSLM_CFG_DELAYS: begin
               pre_delay  <= reg_wdata_in[7:0];
               lead_delay <= reg_wdata_in[15:8];
               hold_delay <= reg_wdata_in[23:16];
               retry_max  <= reg_wdata_in[31:24];
            end
            `PSLM_CFG_POLL: poll_limit <= reg_wdata_in[15:0];
            `PSLM_CFG_CTRL: begin
               suppress <= reg_wdata_in[`PSLM_CTRL_SUPPRESS];
               dtr      <= reg_wdata_in[`PSLM_CTRL_DTR];
            end
            default: ;
         endcase
      end
   end

   // poll supervision: runs while own message waits, restarts on each poll
   always_ff @(posedge core_clk_in) begin
      if (rst_in || !msg_pending_in || poll_in) begin
         poll_timer <= 16'h0;
      end else if (slow_tick && poll_limit != 16'h0 && !poll_expire) begin // RULE1 RULE4
         poll_timer <= poll_timer + 16'h1;
      end
   end
   assign poll_expire = (poll_limit != 16'h0) && (poll_timer >= poll_limit); // RULE4

   // message error and timeout flags, set wins over the clear at new message
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         msg_error <= 1'b0;
         msg_tmo   <= 1'b0;
      end else if (msg_pending_in && msg_timeout_in && !poll_expire) begin
         msg_error <= 1'b1; // RULE3
         msg_tmo   <= 1'b1; // RULE3
      end else if (msg_pending_in && poll_expire) begin
         msg_error <= 1'b1; // RULE2
      end else if (state == pslm_pkg::ST_IDLE && msg_pending_in && !msg_error) begin
         msg_tmo <= 1'b0;
      end else if (reg_wr_in && reg_addr_in == `PSLM_CFG_CTRL && reg_wdata_in[2]) begin
         msg_error <= 1'b0;
         msg_tmo   <= 1'b0;
      end
   end

   // give up once every retry is used
   assign retry_send = (nak_in || ack_timeout_in) && state == pslm_pkg::ST_WAIT_ACK;
   assign give_up    = retry_send && retries >= retry_max; // RULE8

   // transmit sequence state
   always_ff @(posedge core_clk_in) begin
      if (rst_in) state <= pslm_pkg::ST_IDLE;
      else        state <= next_state;
   end

   // next state of the modem handshake sequence
   always_comb begin
      next_state = state;
      unique case (state)
         pslm_pkg::ST_IDLE:
            if (msg_pending_in && poll_in && !poll_expire) next_state = pslm_pkg::ST_PRE;
         pslm_pkg::ST_PRE:  // RULE9
            if (delay_cnt >= pre_delay) next_state = pslm_pkg::ST_LEAD;
         pslm_pkg::ST_LEAD: // RULE6
            if (delay_cnt >= lead_delay) next_state = pslm_pkg::ST_WAIT_CTS;
         pslm_pkg::ST_WAIT_CTS: // RULE7
            if (cts_s[1]) next_state = pslm_pkg::ST_SEND;
         pslm_pkg::ST_SEND:
            if (tx_done_in) next_state = pslm_pkg::ST_HOLD;
         pslm_pkg::ST_HOLD: // RULE5
            if (delay_cnt >= hold_delay) next_state = pslm_pkg::ST_WAIT_ACK;
         pslm_pkg::ST_WAIT_ACK:
            if (ack_in || give_up) next_state = pslm_pkg::ST_IDLE;
            else if (retry_send) next_state = pslm_pkg::ST_PRE; // RULE8
      endcase
   end

   // delay counter in 1 ms or 20 ms units, cleared on each state change
   always_ff @(posedge core_clk_in) begin
      if (rst_in || next_state != state) begin
         delay_cnt <= 8'h0;
      end else if ((state == pslm_pkg::ST_PRE && ms_tick) ||
                   ((state == pslm_pkg::ST_LEAD || state == pslm_pkg::ST_HOLD) && slow_tick)) begin
         delay_cnt <= delay_cnt + 8'h1;
      end
   end

   // retry counter for the current message
   always_ff @(posedge core_clk_in) begin
      if (rst_in || state == pslm_pkg::ST_IDLE) retries <= 8'h0;
      else if (retry_send && !give_up)          retries <= retries + 8'h1; // RULE8
   end

   // modem and message outputs
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         rts_out         <= 1'b0;
         tx_start_out    <= 1'b0;
         eot_send_out    <= 1'b0;
         msg_discard_out <= 1'b0;
         msg_done_out    <= 1'b0;
      end else begin
         rts_out <= next_state == pslm_pkg::ST_LEAD || next_state == pslm_pkg::ST_WAIT_CTS ||
                    next_state == pslm_pkg::ST_SEND || next_state == pslm_pkg::ST_HOLD; // RULE5 RULE6
         tx_start_out    <= state == pslm_pkg::ST_WAIT_CTS && cts_s[1]; // RULE7
         eot_send_out    <= poll_in && !msg_pending_in && !suppress &&
                            state == pslm_pkg::ST_IDLE; // RULE10 RULE11
         msg_discard_out <= msg_pending_in && poll_expire && !msg_error; // RULE2
         msg_done_out    <= ack_in && state == pslm_pkg::ST_WAIT_ACK || give_up;
      end
   end
   assign msg_error_out        = msg_error;
   assign msg_timeout_flag_out = msg_tmo;
   assign dtr_out              = dtr;

   // diagnostic event counters
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         for (int i = 1; i <= 12; i++) cnt[i] <= 16'h0; // RULE23
      end else begin
         cnt[1]  <= bump(cnt[1], tx_start_out);                 // RULE14
         cnt[2]  <= bump(cnt[2], rx_good_in);                   // RULE15
         cnt[3]  <= bump(cnt[3], give_up);                      // RULE16
         cnt[4]  <= bump(cnt[4], tx_start_out && retries != 8'h0); // RULE17
         cnt[5]  <= bump(cnt[5], nak_in);                       // RULE18
         cnt[6]  <= bump(cnt[6], poll_in);                      // RULE18
         cnt[7]  <= bump(cnt[7], rx_corrupt_in);                // RULE19
         cnt[8]  <= bump(cnt[8], rx_nobuf_in);                  // RULE20
         cnt[9]  <= bump(cnt[9], rx_repeat_in);                 // RULE21
         cnt[10] <= 16'h0;                                      // unused slot
         cnt[11] <= bump(cnt[11], dcd_s[1] && !dcd_q);          // RULE22
         cnt[12] <= bump(cnt[12], lost_s[1] && !lost_q);        // RULE22
      end
   end

   // register read, data one cycle after the strobe
   always_ff @(posedge core_clk_in) begin
      if (rst_in || !reg_rd_in) begin
         reg_rdata_out <= 32'h0;
      end else begin
         unique case (reg_addr_in)
            `PSLM_HS_STATUS: reg_rdata_out <= {27'h0, dtr, dcd_s[1], dsr_s[1], rts_out, cts_s[1]}; // RULE13
            `PSLM_CFG_DELAYS: reg_rdata_out <= {retry_max, hold_delay, lead_delay, pre_delay};
            `PSLM_CFG_POLL:   reg_rdata_out <= {16'h0, poll_limit};
            `PSLM_CFG_CTRL:   reg_rdata_out <= {26'h0, msg_tmo, msg_error, 1'b0, 1'b0, dtr, suppress};
            4'hA:            reg_rdata_out <= 32'h0;
            default:         reg_rdata_out <= {16'h0, cnt[reg_addr_in]};
         endcase
      end
   end

   // rts is released only after the hold state
   a_rts_hold: assert property (@(posedge core_clk_in) disable iff (rst_in) // RULE5
      state == pslm_pkg::ST_HOLD |=> rts_out || state != pslm_pkg::ST_HOLD)
      else $error("rts dropped during hold");
   // start only with synced clear-to-send
   a_cts_gate: assert property (@(posedge core_clk_in) disable iff (rst_in) // RULE7
      tx_start_out |-> $past(cts_s[1]))
      else $error("send started without cts");
   // no-data reply silenced when suppressing
   a_eot_quiet: assert property (@(posedge core_clk_in) disable iff (rst_in) // RULE10
      $past(suppress) |-> !eot_send_out)
      else $error("no-data packet sent while suppressed");
   // zero timeout never expires
   a_poll_off: assert property (@(posedge core_clk_in) disable iff (rst_in) // RULE4
      poll_limit == 16'h0 |-> !poll_expire)
      else $error("poll timeout with zero limit");
   // timeout flag implies error flag
   a_tmo_err: assert property (@(posedge core_clk_in) disable iff (rst_in) // RULE3
      msg_tmo |-> msg_error)
      else $error("timeout without error");
   // send counter follows start pulse
   a_tx_count: assert property (@(posedge core_clk_in) disable iff (rst_in) // RULE14
      tx_start_out |=> cnt[1] == $past(cnt[1]) + 16'h1)
      else $error("send not counted");
   // poll counter follows poll
   a_poll_count: assert property (@(posedge core_clk_in) disable iff (rst_in) // RULE18
      poll_in |=> cnt[6] == $past(cnt[6]) + 16'h1)
      else $error("poll not counted");
   // rts raised before send
   a_rts_lead: assert property (@(posedge core_clk_in) disable iff (rst_in) // RULE6
      tx_start_out |-> rts_out)
      else $error("send without rts");
endmodule : pslm_link_ctrl

// [bench/pslm_master_model.sv]
// bench model of the polling master station and its half-duplex modem
// assumes the controller's rts and tx_start on the same core clock
`timescale 1ns/1ps
module pslm_master_model #(
   parameter int CTS_LAG = 30  // modem warm-up cycles
) (
   input  wire logic       core_clk_in,
   input  wire logic       rst_in,
   input  wire logic       rts_in,
   input  wire logic       tx_start_in,
   input  wire logic [1:0] reply_mode_in,  // 0 ack, 1 nak, 2 no answer
   output logic            cts_out,
   output logic            tx_done_out,
   output logic            ack_out,
   output logic            nak_out,
   output logic            ack_timeout_out
);
   int   lag;       // cycles since rts rose
   int   send_cnt;  // serialiser countdown
   int   turn_cnt;  // line turnaround countdown
   logic rts_q;     // rts one cycle back
   // modem grants clear-to-send only after warm-up, drops it with rts
   always_ff @(posedge core_clk_in) begin
      if (rst_in || !rts_in) lag <= 0;
      else if (lag < CTS_LAG) lag <= lag + 1;
      cts_out <= !rst_in && rts_in && lag == CTS_LAG;
   end
   // last byte leaves 16 cycles after start; master answers after turnaround
   // silence after a poll is simply taken as no data, nothing is awaited
   always_ff @(posedge core_clk_in) begin
      rts_q           <= rts_in;
      tx_done_out     <= !rst_in && send_cnt == 1;
      ack_out         <= !rst_in && turn_cnt == 1 && reply_mode_in == 2'h0;
      nak_out         <= !rst_in && turn_cnt == 1 && reply_mode_in == 2'h1;
      ack_timeout_out <= !rst_in && turn_cnt == 1 && reply_mode_in == 2'h2;
      if (rst_in) begin
         send_cnt <= 0;
         turn_cnt <= 0;
      end else begin
         send_cnt <= tx_start_in ? 16 : (send_cnt > 0 ? send_cnt - 1 : 0);
         turn_cnt <= (rts_q && !rts_in) ? 8 : (turn_cnt > 0 ? turn_cnt - 1 : 0);
      end
   end
endmodule : pslm_master_model

// [bench/polled_slave_modem_link_ctrl_tb_top.sv]
// self-checking bench of the slave modem link controller
// assumes the master model in its own file and a 10-cycle millisecond
`timescale 1ns/1ps
`include "pslm_map.svh"
module polled_slave_modem_link_ctrl_tb_top;
   localparam int MS   = 10;      // shortened millisecond
   localparam int SLOW = 20 * MS; // cycles per 20 ms tick
   localparam int LAG  = 30;      // modem warm-up cycles before clear-to-send
   localparam logic [3:0] EV_IDX [6] = '{4'h6, 4'h2, 4'h7, 4'h8, 4'h9, 4'h5}; // counter per event
   logic        core_clk_in = 0, rst_in = 1;
   logic [31:0] reg_wdata_in = '0;
   logic [31:0] reg_rdata_out;
   logic [3:0]  reg_addr_in = '0;
   logic        reg_wr_in = 0, reg_rd_in = 0, dsr_in = 0, dcd_in = 0, modem_lost_in = 0;
   logic        msg_pending_in = 0, msg_timeout_in = 0, poll_in = 0, nak_tb = 0;
   logic        rx_good_in = 0, rx_corrupt_in = 0, rx_nobuf_in = 0, rx_repeat_in = 0;
   logic        cts, tx_done, ack, nak_m, ack_to, rts_out, dtr_out, tx_start_out, eot_send_out;
   logic        msg_error_out, msg_timeout_flag_out, msg_discard_out, msg_done_out;
   logic [1:0]  reply_mode = 2'h0;  // master answer kind
   logic [15:0] lfsr = 16'hBDDF;    // seed 48607
   logic [15:0] exp_cnt [16];       // expected counter values
   int          n_mismatch = 0, tests_run = 0, n_eot = 0, cyc = 0;
   // free-running clock and cycle count
   always #4 core_clk_in = ~core_clk_in;
   always @(posedge core_clk_in) cyc <= cyc + 1;
   // tally of no-data replies
   always @(posedge core_clk_in) if (eot_send_out === 1'b1) n_eot <= n_eot + 1;
   pslm_link_ctrl #(.MS_CYCLES(MS)) i_pslm_link_ctrl (.core_clk_in, .rst_in, .reg_addr_in, .reg_wdata_in,
      .reg_wr_in, .reg_rd_in, .reg_rdata_out, .cts_in(cts), .dsr_in, .dcd_in, .modem_lost_in, .rts_out,
      .dtr_out, .msg_pending_in, .msg_timeout_in, .poll_in, .ack_in(ack), .nak_in(nak_m | nak_tb),
      .ack_timeout_in(ack_to), .rx_good_in, .rx_corrupt_in, .rx_nobuf_in, .rx_repeat_in,
      .tx_done_in(tx_done), .tx_start_out, .eot_send_out, .msg_error_out, .msg_timeout_flag_out,
      .msg_discard_out, .msg_done_out);
   pslm_master_model #(.CTS_LAG(LAG)) i_pslm_master_model (.core_clk_in, .rst_in, .rts_in(rts_out),
      .tx_start_in(tx_start_out), .reply_mode_in(reply_mode), .cts_out(cts), .tx_done_out(tx_done), .ack_out(ack),
      .nak_out(nak_m), .ack_timeout_out(ack_to));
   // next random word
   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr_next
   // expected handshake status word
   function automatic logic [31:0] status_exp(input logic dtr, dcd, dsr, rts, cts_l);
      return {27'h0, dtr, dcd, dsr, rts, cts_l};
   endfunction : status_exp
   // counted comparison
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // one-cycle register write
   task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge core_clk_in);
      reg_wr_in    <= 1'b1;
      reg_addr_in  <= a;
      reg_wdata_in <= d;
      @(posedge core_clk_in);
      reg_wr_in <= 1'b0;
   endtask : reg_wr
   // one-cycle read, data taken in the following cycle
   task automatic reg_chk(input logic [3:0] a, input logic [31:0] e);
      @(posedge core_clk_in);
      reg_rd_in   <= 1'b1;
      reg_addr_in <= a;
      @(posedge core_clk_in);
      reg_rd_in <= 1'b0;
      #1 chk($sformatf("register %h", a), e, reg_rdata_out);
   endtask : reg_chk
   // random received events and modem line changes, two cycles a step
   task automatic rand_phase(input logic sup);
      int polls;
      int e0;
      polls = 0;
      reg_wr(`PSLM_CFG_CTRL, {30'h0, 1'b1, sup});
      e0 = n_eot;
      repeat (40) begin
         lfsr = lfsr_next(lfsr);
         @(posedge core_clk_in);
         poll_in       <= lfsr[2:0] == 3'h0;
         rx_good_in    <= lfsr[2:0] == 3'h1;
         rx_corrupt_in <= lfsr[2:0] == 3'h2;
         rx_nobuf_in   <= lfsr[2:0] == 3'h3;
         rx_repeat_in  <= lfsr[2:0] == 3'h4;
         nak_tb        <= lfsr[2:0] == 3'h5;
         dcd_in        <= lfsr[8];
         modem_lost_in <= lfsr[9];
         dsr_in        <= lfsr[10];
         if (lfsr[2:0] < 3'h6) exp_cnt[EV_IDX[lfsr[2:0]]]++;
         if (lfsr[2:0] == 3'h0) polls++;
         if (lfsr[8] && !dcd_in) exp_cnt[11]++;
         if (lfsr[9] && !modem_lost_in) exp_cnt[12]++;
         @(posedge core_clk_in);
         {poll_in, rx_good_in, rx_corrupt_in, rx_nobuf_in, rx_repeat_in, nak_tb} <= 6'h00;
      end
      repeat (6) @(posedge core_clk_in);
      chk("no-data replies", e0 + (sup ? 0 : polls), n_eot);
      reg_chk(`PSLM_HS_STATUS, status_exp(1'b1, dcd_in, dsr_in, 1'b0, 1'b0));
   endtask : rand_phase
   // one own message: poll, delays, sends, master answers by mode
   task automatic xfer(input logic [1:0] mode, input int hold, input int n_send);
      int t_poll, t_rise, t_done, sent, k, lo;
      logic rts_q, first;
      reply_mode <= mode;
      // no lead delay in mode 2, so the start has to wait for the slow modem
      reg_wr(`PSLM_CFG_DELAYS, {8'h02, hold[7:0], (mode == 2'h2 ? 8'h00 : 8'h02), 8'h03});
      @(posedge core_clk_in);
      msg_pending_in <= 1'b1;
      poll_in        <= 1'b1;
      @(posedge core_clk_in);
      poll_in <= 1'b0;
      t_poll = cyc;
      {sent, rts_q, first, t_rise, t_done} = {32'h0, 1'b0, 1'b1, 32'h0, 32'h0};
      lo = hold == 0 ? 0 : (hold - 1) * SLOW;
      for (k = 0; k < 4000 && msg_done_out !== 1'b1; k++) begin
         @(posedge core_clk_in);
         #1;
         if (rts_out === 1'b1 && !rts_q) begin
            if (first) chk("pre delay", 1, (cyc - t_poll) inside {[2 * MS : 3 * MS + 8]});
            first = 0;
            t_rise = cyc;
         end
         if (tx_start_out === 1'b1) begin
            sent++;
            chk("cts at start", 1, cts);
            if (mode == 2'h2) chk("cts wait", 1, (cyc - t_rise) inside {[LAG : LAG + 8]});
            else chk("lead delay", 1, (cyc - t_rise) inside {[SLOW : 2 * SLOW + 8]});
         end
         if (tx_done === 1'b1) t_done = cyc;
         if (rts_out !== 1'b1 && rts_q) chk("hold delay", 1, (cyc - t_done) inside {[lo : hold * SLOW + 4]});
         rts_q = rts_out;
      end
      msg_pending_in <= 1'b0;
      chk("message done", 1, msg_done_out);
      chk("sends", n_send, sent);
      exp_cnt[6]++;
      exp_cnt[1] += n_send;
      exp_cnt[4] += n_send - 1;
      if (mode == 2'h1) exp_cnt[5] += n_send;
      if (mode != 2'h0) exp_cnt[3]++;
   endtask : xfer
   // verdict and end of run
   task automatic end_of_test();
      $display("tests_run %0d n_mismatch %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : end_of_test
   // hang guard
   initial begin
      repeat (40000) @(posedge core_clk_in);
      n_mismatch++;
      $display("[ERR] watchdog expected finish seen hang");
      end_of_test();
   end
   // main sequence
   initial begin
      int t;
      int seen;
      foreach (exp_cnt[i]) exp_cnt[i] = 16'h0000;
      repeat (10) @(posedge core_clk_in);
      rst_in <= 1'b0;
      reg_chk(`PSLM_HS_STATUS, 32'h10);
      for (int i = 1; i < 13; i++) reg_chk(i[3:0], 32'h0);
      reg_wr(`PSLM_TX_MSG_CNT, 32'hFFFF);
      reg_chk(`PSLM_TX_MSG_CNT, 32'h0);
      reg_wr(`PSLM_CFG_POLL, 32'h0);
      rand_phase(1'b0);
      rand_phase(1'b1);
      xfer(2'h1, 0, 3);
      xfer(2'h0, 2, 1);
      xfer(2'h2, 0, 3);
      reg_wr(`PSLM_CFG_POLL, 32'h2);
      @(posedge core_clk_in);
      msg_pending_in <= 1'b1;
      t = cyc;
      for (int k = 0; k < 3 * SLOW && msg_discard_out !== 1'b1; k++) begin
         @(posedge core_clk_in);
         #1;
      end
      chk("poll timeout span", 1, (cyc - t) inside {[SLOW : 2 * SLOW + 8]});
      repeat (2) @(posedge core_clk_in);
      chk("error flag", 1, msg_error_out);
      chk("timeout flag", 0, msg_timeout_flag_out);
      msg_pending_in <= 1'b0;
      reg_wr(`PSLM_CFG_CTRL, 32'h6);
      reg_wr(`PSLM_CFG_POLL, 32'h0);
      msg_pending_in <= 1'b1;
      seen = 0;
      repeat (3 * SLOW) @(posedge core_clk_in) if (msg_discard_out !== 1'b0 || msg_error_out !== 1'b0) seen++;
      chk("disabled supervision", 0, seen);
      msg_timeout_in <= 1'b1;
      repeat (3) @(posedge core_clk_in);
      chk("error flag", 1, msg_error_out);
      chk("timeout flag", 1, msg_timeout_flag_out);
      msg_pending_in <= 1'b0;
      msg_timeout_in <= 1'b0;
      for (int i = 1; i < 13; i++) reg_chk(i[3:0], {16'h0, exp_cnt[i]});
      // terminal-ready pin and its status bit follow the control bit
      reg_wr(`PSLM_CFG_CTRL, 32'h0);
      #1 chk("dtr pin", 0, dtr_out);
      reg_chk(`PSLM_HS_STATUS, status_exp(1'b0, dcd_in, dsr_in, 1'b0, 1'b0));
      end_of_test();
   end
endmodule : polled_slave_modem_link_ctrl_tb_top
